// ### rtl/core_debug_mode_control.sv
`timescale 1ns/10ps
module core_debug_mode_control (
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        fetch_enable_i,
   input  wire logic        debug_req_i,
   input  wire logic [31:0] halt_entry_address_in,
   input  wire logic [31:0] halt_exception_address_in,
   input  wire logic        dec_valid_i,
   input  wire logic [31:0] dec_pc_i,
   input  wire logic        dec_ebreak_i,
   input  wire logic        dec_mret_i,
   input  wire logic        dec_dret_i,
   input  wire logic        dec_exc_i,
   input  wire logic [4:0]  dec_exc_code_i,
   input  wire logic [31:0] irq_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             debug_havereset_o,
   output logic             debug_running_o,
   output logic             debug_halted_o,
   output logic             redirect_o,
   output logic [31:0]      redirect_pc_o,
   output logic             kill_decode_o,
   output logic             irq_ack_o,
   output logic [4:0]       irq_id_o
);

   dbg_ctrl_pkg::dbg_state_t state_q;
   logic        pend_q;
   logic        ebreakm_q;
   logic [2:0]  cause_q;
   logic [31:0] dpc_q;
   logic [31:0] dscr0_q;
   logic [31:0] dscr1_q;
   logic        trig_en_q;
   logic [31:0] tdata2_q;
   logic        mie_q;
   logic        mpie_q;
   logic [31:0] mepc_q;
   logic [31:0] mcause_q;
   logic [31:0] mtvec_q;
   logic [31:0] mien_q;
   logic        in_dbg;
   logic        trig_hit;
   logic        dbg_entry;
   logic        exc_take;
   logic        irq_take;
   logic [31:0] irq_act;
   logic [4:0]  irq_sel;
   logic        irq_any;
   logic        apb_wr;
   logic        dbg_reg;
   logic        trg_reg;
   logic        mapped;
   logic [2:0]  entry_cause;

   ////////////////////////////////////////////////////////////////////////////
   // Event decode.

   // Debug mode is exactly the halted state, so the flag cannot disagree with the status.
   assign in_dbg   = (state_q == dbg_ctrl_pkg::ST_HALT);
   // Address match on the instruction in decode; only one trigger exists.
   assign trig_hit = trig_en_q && dec_valid_i && (dec_pc_i == tdata2_q);
   // Any of three sources halts the running core.
   assign dbg_entry = (state_q == dbg_ctrl_pkg::ST_RUN) &&
                      (debug_req_i || trig_hit ||
                       (dec_valid_i && dec_ebreak_i && ebreakm_q));
   // Ebreak without EBREAKM is an ordinary breakpoint trap.
   assign exc_take = (state_q == dbg_ctrl_pkg::ST_RUN) && !dbg_entry && dec_valid_i &&
                     (dec_exc_i || (dec_ebreak_i && !ebreakm_q));
   // Interrupts are masked outright while halted.
   assign irq_act  = irq_i & mien_q;
   assign irq_take = (state_q == dbg_ctrl_pkg::ST_RUN) && !dbg_entry && !exc_take &&
                     mie_q && irq_any;

   // Trigger has top priority, then ebreak, then the external request.
   always_comb begin
      if (trig_hit) begin
         entry_cause = dbg_ctrl_pkg::CAUSE_TRIGGER;
      end else if (dec_valid_i && dec_ebreak_i && ebreakm_q) begin
         entry_cause = dbg_ctrl_pkg::CAUSE_EBREAK;
      end else begin
         entry_cause = dbg_ctrl_pkg::CAUSE_HALTREQ;
      end
   end

   // Highest pending ID wins; the scan runs upward so later hits override.
   always_comb begin
      irq_sel = 5'h00;
      irq_any = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (irq_act[i]) begin
            irq_sel = 5'(i);
            irq_any = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debug state machine and status pins.

   // Reset holds the unavailable state until fetch enable is seen high.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state_q <= dbg_ctrl_pkg::ST_RESET;
      end else begin
         case (state_q)
            dbg_ctrl_pkg::ST_RESET: begin
               if (fetch_enable_i) begin
                  // A request seen before fetch enable skips running.
                  state_q <= (pend_q || debug_req_i) ? dbg_ctrl_pkg::ST_HALT
                                                     : dbg_ctrl_pkg::ST_RUN;
               end
            end
            dbg_ctrl_pkg::ST_RUN: begin
               if (dbg_entry) begin
                  state_q <= dbg_ctrl_pkg::ST_HALT;
               end
            end
            dbg_ctrl_pkg::ST_HALT: begin
               if (dec_valid_i && dec_dret_i) begin
                  state_q <= dbg_ctrl_pkg::ST_RUN;
               end
            end
            default: state_q <= dbg_ctrl_pkg::ST_RESET;
         endcase
      end
   end

   // Remembers a request seen while still unavailable; relies on a clean synchronous level.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pend_q <= 1'b0;
      end else if (state_q == dbg_ctrl_pkg::ST_RESET) begin
         pend_q <= pend_q || debug_req_i;
      end else begin
         pend_q <= 1'b0;
      end
   end

   // Status pins are one-hot copies of the next state, so they change with it.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         debug_havereset_o <= 1'b1;
         debug_running_o   <= 1'b0;
         debug_halted_o    <= 1'b0;
      end else begin
         case (state_q)
            dbg_ctrl_pkg::ST_RESET: begin
               debug_havereset_o <= !fetch_enable_i;
               debug_running_o   <= fetch_enable_i && !(pend_q || debug_req_i);
               debug_halted_o    <= fetch_enable_i && (pend_q || debug_req_i);
            end
            dbg_ctrl_pkg::ST_RUN: begin
               debug_havereset_o <= 1'b0;
               debug_running_o   <= !dbg_entry;
               debug_halted_o    <= dbg_entry;
            end
            default: begin
               debug_havereset_o <= 1'b0;
               debug_running_o   <= dec_valid_i && dec_dret_i;
               debug_halted_o    <= !(dec_valid_i && dec_dret_i);
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch redirection.

   // One-cycle redirect pulse; the decode slot is killed with it, except on a running-mode mret or a dret redirect.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         redirect_o    <= 1'b0;
         redirect_pc_o <= 32'h0000_0000;
         kill_decode_o <= 1'b0;
      end else begin
         redirect_o    <= 1'b0;
         kill_decode_o <= 1'b0;
         if ((state_q == dbg_ctrl_pkg::ST_RESET) && fetch_enable_i &&
             (pend_q || debug_req_i)) begin
            redirect_o    <= 1'b1;
            kill_decode_o <= 1'b1;
            redirect_pc_o <= halt_entry_address_in;
         end else if (dbg_entry) begin
            redirect_o    <= 1'b1;
            kill_decode_o <= 1'b1;
            redirect_pc_o <= halt_entry_address_in;
         end else if (exc_take) begin
            redirect_o    <= 1'b1;
            kill_decode_o <= 1'b1;
            redirect_pc_o <= {mtvec_q[31:2], 2'b00};
         end else if (irq_take) begin
            redirect_o    <= 1'b1;
            kill_decode_o <= 1'b1;
            redirect_pc_o <= mtvec_q[0] ? ({mtvec_q[31:8], 8'h00} + {25'h0, irq_sel, 2'b00})
                                        : {mtvec_q[31:2], 2'b00};
         end else if ((state_q == dbg_ctrl_pkg::ST_RUN) && dec_valid_i && dec_mret_i) begin
            redirect_o    <= 1'b1;
            redirect_pc_o <= mepc_q;
         end else if (in_dbg && dec_valid_i) begin
            // Supplied addresses are used unmodified; they must be aligned.
            if (dec_dret_i) begin
               redirect_o    <= 1'b1;
               redirect_pc_o <= dpc_q;
            end else if (dec_ebreak_i) begin
               redirect_o    <= 1'b1;
               kill_decode_o <= 1'b1;
               redirect_pc_o <= halt_entry_address_in;
            end else if (dec_exc_i || dec_mret_i) begin
               redirect_o    <= 1'b1;
               kill_decode_o <= 1'b1;
               redirect_pc_o <= halt_exception_address_in;
            end
         end
      end
   end

   // Acknowledge pulse for the interrupt controller.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         irq_ack_o <= 1'b0;
         irq_id_o  <= 5'h00;
      end else begin
         irq_ack_o <= irq_take;
         if (irq_take) begin
            irq_id_o <= irq_sel;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave; one wait state, write lands on the edge that samples pready.

   assign apb_wr  = psel && penable && pready && pwrite;
   assign dbg_reg = (paddr == dbg_ctrl_pkg::OFS_DCSR) || (paddr == dbg_ctrl_pkg::OFS_DPC) ||
                    (paddr == dbg_ctrl_pkg::OFS_DSCR0) || (paddr == dbg_ctrl_pkg::OFS_DSCR1);
   assign trg_reg = (paddr == dbg_ctrl_pkg::OFS_TSELECT) || (paddr == dbg_ctrl_pkg::OFS_TDATA1) ||
                    (paddr == dbg_ctrl_pkg::OFS_TDATA2) || (paddr == dbg_ctrl_pkg::OFS_TINFO);
   assign mapped  = dbg_reg || trg_reg || (paddr == dbg_ctrl_pkg::OFS_MSTATUS) ||
                    (paddr == dbg_ctrl_pkg::OFS_MEPC) || (paddr == dbg_ctrl_pkg::OFS_MCAUSE) ||
                    (paddr == dbg_ctrl_pkg::OFS_MTVEC) || (paddr == dbg_ctrl_pkg::OFS_MIE) ||
                    (paddr == dbg_ctrl_pkg::OFS_DSTATE);

   // Read data and error are set up in the wait cycle and shown with pready.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && (!mapped || (dbg_reg && !in_dbg));
         prdata  <= 32'h0000_0000;
         if (psel && penable && !pready && !pwrite && !(dbg_reg && !in_dbg)) begin
            case (paddr)
               dbg_ctrl_pkg::OFS_DCSR:    prdata <= dbg_ctrl_pkg::DCSR_CONST |
                                             (32'(ebreakm_q) << dbg_ctrl_pkg::DCSR_EBREAKM_POS) |
                                             (32'(cause_q) << dbg_ctrl_pkg::DCSR_CAUSE_LSB);
               dbg_ctrl_pkg::OFS_DPC:     prdata <= dpc_q;
               dbg_ctrl_pkg::OFS_DSCR0:   prdata <= dscr0_q;
               dbg_ctrl_pkg::OFS_DSCR1:   prdata <= dscr1_q;
               dbg_ctrl_pkg::OFS_TDATA1:  prdata <= dbg_ctrl_pkg::TD1_CONST |
                                             (32'h1 << dbg_ctrl_pkg::TD1_DMODE_POS) |
                                             (32'(trig_en_q) << dbg_ctrl_pkg::TD1_EXEC_POS);
               dbg_ctrl_pkg::OFS_TDATA2:  prdata <= tdata2_q;
               dbg_ctrl_pkg::OFS_TINFO:   prdata <= dbg_ctrl_pkg::TINFO_VALUE;
               dbg_ctrl_pkg::OFS_MSTATUS: prdata <= (32'(mie_q) << dbg_ctrl_pkg::MST_MIE_POS) |
                                             (32'(mpie_q) << dbg_ctrl_pkg::MST_MPIE_POS);
               dbg_ctrl_pkg::OFS_MEPC:    prdata <= mepc_q;
               dbg_ctrl_pkg::OFS_MCAUSE:  prdata <= mcause_q;
               dbg_ctrl_pkg::OFS_MTVEC:   prdata <= mtvec_q;
               dbg_ctrl_pkg::OFS_MIE:     prdata <= mien_q;
               dbg_ctrl_pkg::OFS_DSTATE:  prdata <= {29'h0, debug_halted_o, debug_running_o,
                                                     debug_havereset_o};
               default:                   prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debug registers: only written in debug mode or by debug entry.

   // Entry hardware update wins over software; PC-dependent code is never flagged.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ebreakm_q <= dbg_ctrl_pkg::EBREAKM_RST;
         cause_q   <= 3'h0;
         dpc_q     <= 32'h0000_0000;
         dscr0_q   <= 32'h0000_0000;
         dscr1_q   <= 32'h0000_0000;
      end else if (dbg_entry ||
                   ((state_q == dbg_ctrl_pkg::ST_RESET) && fetch_enable_i &&
                    (pend_q || debug_req_i))) begin
         dpc_q   <= dec_pc_i;
         cause_q <= dbg_entry ? entry_cause : dbg_ctrl_pkg::CAUSE_HALTREQ;
      end else if (apb_wr && in_dbg) begin
         case (paddr)
            dbg_ctrl_pkg::OFS_DCSR:  ebreakm_q <= pwdata[dbg_ctrl_pkg::DCSR_EBREAKM_POS];
            dbg_ctrl_pkg::OFS_DPC:   dpc_q     <= pwdata;
            dbg_ctrl_pkg::OFS_DSCR0: dscr0_q   <= pwdata;
            dbg_ctrl_pkg::OFS_DSCR1: dscr1_q   <= pwdata;
            default:                 dpc_q     <= dpc_q;
         endcase
      end
   end

   // Trigger writes are dropped outside debug mode; reads stay open.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         trig_en_q <= 1'b0;
         tdata2_q  <= 32'h0000_0000;
      end else if (apb_wr && in_dbg) begin
         if (paddr == dbg_ctrl_pkg::OFS_TDATA1) begin
            trig_en_q <= pwdata[dbg_ctrl_pkg::TD1_EXEC_POS];
         end else if (paddr == dbg_ctrl_pkg::OFS_TDATA2) begin
            tdata2_q <= pwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Machine trap registers.

   // Single-level save only: a second trap before software saves would overwrite.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         mie_q    <= 1'b0;
         mpie_q   <= 1'b0;
         mepc_q   <= 32'h0000_0000;
         mcause_q <= 32'h0000_0000;
         mtvec_q  <= dbg_ctrl_pkg::MTVEC_RST;
         mien_q   <= 32'h0000_0000;
      end else if (exc_take || irq_take) begin
         mpie_q   <= mie_q;
         mie_q    <= 1'b0;
         mepc_q   <= dec_pc_i;
         mcause_q <= irq_take ? {1'b1, 26'h0, irq_sel} :
                     (dec_exc_i ? {27'h0, dec_exc_code_i} : dbg_ctrl_pkg::EXC_BREAK);
      end else if ((state_q == dbg_ctrl_pkg::ST_RUN) && dec_valid_i && dec_mret_i) begin
         mie_q  <= mpie_q;
         mpie_q <= 1'b1;
      end else if (apb_wr) begin
         case (paddr)
            dbg_ctrl_pkg::OFS_MSTATUS: begin
               mie_q  <= pwdata[dbg_ctrl_pkg::MST_MIE_POS];
               mpie_q <= pwdata[dbg_ctrl_pkg::MST_MPIE_POS];
            end
            dbg_ctrl_pkg::OFS_MEPC:   mepc_q   <= pwdata;
            dbg_ctrl_pkg::OFS_MCAUSE: mcause_q <= pwdata;
            dbg_ctrl_pkg::OFS_MTVEC:  mtvec_q  <= pwdata;
            dbg_ctrl_pkg::OFS_MIE:    mien_q   <= pwdata;
            default:                  mepc_q   <= mepc_q;
         endcase
      end
   end

endmodule : core_debug_mode_control

// ### rtl/dbg_ctrl_pkg.sv
// Operation
// - Entering any trap handler clears the global interrupt enable.
// - No hardware nesting; software re-enables interrupts after saving state.
// - Debug entry saves PC to DPC, records cause, fetches at halt address.
// - Enter debug on request, trigger match, or ebreak with EBREAKM set.
// - One trigger, instruction address match only, match enters debug.
// - No illegal instruction for program buffer transfers or PC-dependent code.
// - Instruction in decode when request rises is not executed first; an mret there still has its MIE and MPIE update applied.
// - Has-been-reset, running and halted are mutually exclusive, one high always.
// - Has-been-reset high in reset, drops after fetch enable seen high.
// - Running high in normal execution, halted high in debug mode.
// - Unavailable until leaving reset state, then running or halted only.
// - Request pending at fetch enable goes straight from unavailable to halted.
// - Request while running reaches halted within a few cycles.
// - Ebreak in debug mode jumps to halt address, CSRs unchanged.
// - Debug exception or mret jumps to exception address, status unchanged.
// - DCSR, DPC and two scratch registers; access outside debug is illegal.
// - Trigger DMODE reads one; outside debug trigger writes ignored, reads work.
// - Ebreak outside debug, EBREAKM clear, traps to mtvec updating MEPC, MCAUSE.
// - Ebreak outside debug, EBREAKM set, enters debug updating DPC and DCSR.
// - EBREAKM resets to zero.
// - Interrupts are ignored in debug mode.
package dbg_ctrl_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_DCSR     = 8'h00;
   localparam logic [7:0] OFS_DPC      = 8'h04;
   localparam logic [7:0] OFS_DSCR0    = 8'h08;
   localparam logic [7:0] OFS_DSCR1    = 8'h0C;
   localparam logic [7:0] OFS_TSELECT  = 8'h10;
   localparam logic [7:0] OFS_TDATA1   = 8'h14;
   localparam logic [7:0] OFS_TDATA2   = 8'h18;
   localparam logic [7:0] OFS_TINFO    = 8'h1C;
   localparam logic [7:0] OFS_MSTATUS  = 8'h20;
   localparam logic [7:0] OFS_MEPC     = 8'h24;
   localparam logic [7:0] OFS_MCAUSE   = 8'h28;
   localparam logic [7:0] OFS_MTVEC    = 8'h2C;
   localparam logic [7:0] OFS_MIE      = 8'h30;
   localparam logic [7:0] OFS_DSTATE   = 8'h34;
   // Field positions.
   localparam int DCSR_EBREAKM_POS = 15;
   localparam int DCSR_CAUSE_LSB   = 6;
   localparam int MST_MIE_POS      = 3;
   localparam int MST_MPIE_POS     = 7;
   localparam int TD1_EXEC_POS     = 2;
   localparam int TD1_DMODE_POS    = 27;
   // Constant read fields.
   localparam logic [31:0] DCSR_CONST   = 32'h4000_0003;
   localparam logic [31:0] TD1_CONST    = 32'h2000_0040;
   localparam logic [31:0] TINFO_VALUE  = 32'h0000_0004;
   // Reset values.
   localparam logic        EBREAKM_RST  = 1'b0;
   localparam logic [31:0] MTVEC_RST    = 32'h0000_0000;
   // Debug entry causes and exception codes.
   localparam logic [2:0]  CAUSE_EBREAK  = 3'h1;
   localparam logic [2:0]  CAUSE_TRIGGER = 3'h2;
   localparam logic [2:0]  CAUSE_HALTREQ = 3'h3;
   localparam logic [31:0] EXC_BREAK     = 32'h0000_0003;
   // Debug states.
   typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_HALT} dbg_state_t;
endpackage : dbg_ctrl_pkg

// ### sim/core_debug_mode_control_assertions.sv
`timescale 1ns/10ps
module core_debug_mode_control_assertions (
   input wire logic        sys_clk_i,
   input wire logic        rstn_i,
   input wire logic        fetch_enable_i,
   input wire logic        debug_req_i,
   input wire logic [31:0] halt_entry_address_in,
   input wire logic [31:0] halt_exception_address_in,
   input wire logic        dec_valid_i,
   input wire logic        dec_ebreak_i,
   input wire logic        dec_mret_i,
   input wire logic        dec_dret_i,
   input wire logic        dec_exc_i,
   input wire logic        debug_havereset_o,
   input wire logic        debug_running_o,
   input wire logic        debug_halted_o,
   input wire logic        redirect_o,
   input wire logic [31:0] redirect_pc_o,
   input wire logic        kill_decode_o,
   input wire logic        irq_ack_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // Debug-mode instruction, not a resume.
   wire in_dbg = debug_halted_o && dec_valid_i && !dec_dret_i;
   sequence s_jump(logic [31:0] a);
      redirect_o && redirect_pc_o == a;
   endsequence
   sequence s_entry;
      s_jump(halt_entry_address_in) ##0 kill_decode_o && debug_halted_o;
   endsequence
   chk_status_onehot: assert property (
      $onehot({debug_havereset_o, debug_running_o, debug_halted_o}))
      else $error("status not one-hot");
   chk_reset_status: assert property (
      disable iff (1'b0) !rstn_i |=> debug_havereset_o)
      else $error("havereset low in reset");
   chk_wait_fetch: assert property (
      debug_havereset_o && !fetch_enable_i |=> debug_havereset_o)
      else $error("left reset without fetch enable");
   chk_leave_reset: assert property (
      debug_havereset_o && fetch_enable_i |=> !debug_havereset_o)
      else $error("havereset stuck");
   chk_early_req: assert property (
      debug_havereset_o && fetch_enable_i && debug_req_i |=> debug_halted_o)
      else $error("early request not halted");
   chk_req_entry: assert property (
      debug_running_o && debug_req_i |=> s_entry)
      else $error("request did not enter debug");
   chk_halt_ebreak: assert property (
      in_dbg && dec_ebreak_i |=> s_jump(halt_entry_address_in) ##0 debug_halted_o)
      else $error("ebreak in debug not restarted");
   chk_halt_exc: assert property (
      in_dbg && !dec_ebreak_i && (dec_exc_i || dec_mret_i)
      |=> s_jump(halt_exception_address_in) ##0 debug_halted_o)
      else $error("debug exception misdirected");
   chk_dret_resume: assert property (
      debug_halted_o && dec_valid_i && dec_dret_i
      |=> debug_running_o && redirect_o && !kill_decode_o)
      else $error("resume failed");
   chk_no_irq_halt: assert property (debug_halted_o |-> !irq_ack_o)
      else $error("irq taken in debug");
endmodule : core_debug_mode_control_assertions
bind core_debug_mode_control core_debug_mode_control_assertions u_chk (
   .sys_clk_i, .rstn_i, .fetch_enable_i, .debug_req_i, .halt_entry_address_in,
   .halt_exception_address_in, .dec_valid_i, .dec_ebreak_i, .dec_mret_i, .dec_dret_i,
   .dec_exc_i, .debug_havereset_o, .debug_running_o, .debug_halted_o, .redirect_o,
   .redirect_pc_o, .kill_decode_o, .irq_ack_o);

// ### sim/dbg_req_source.sv
`timescale 1ns/10ps
module dbg_req_source (
   input  wire logic       sys_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       start_i,
   input  wire logic [7:0] hold_i,
   output logic            debug_req_o
);
   logic [7:0] left_q;
   // Never shorter than a cycle, or the core might not see it.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         left_q <= 8'h00;
      end else if (start_i) begin
         left_q <= (hold_i == 8'h00) ? 8'h01 : hold_i;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   assign debug_req_o = (left_q != 8'h00);
endmodule : dbg_req_source

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
   logic        sys_clk_i = 1'b0, rstn_i = 1'b0, fetch_enable_i = 1'b0, req_go = 1'b0;
   logic [7:0]  req_len = 8'h04, paddr = 8'h00;
   logic        dv = 1'b0, deb = 1'b0, dmr = 1'b0, ddr = 1'b0, dex = 1'b0, er, debug_req;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [31:0] dpc = 32'h0, irq = 32'h0, pwdata = 32'h0, prdata, rdv, pc, r, rpc;
   logic        hr, run, hlt, rdr, kill, ack;
   logic [4:0]  iid;
   wire  [31:0] st = {29'h0, hr, run, hlt};
   int          err_total = 0, cmp_count = 0, cyc = 0, acks = 0;
   // Word-aligned, as the integrator must supply them.
   logic [31:0] hadr = 32'h0000_1A00;
   logic [31:0] xadr = 32'h0000_1A80;
   dbg_req_source u_dm (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .start_i(req_go),
      .hold_i(req_len), .debug_req_o(debug_req));
   core_debug_mode_control dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
      .fetch_enable_i(fetch_enable_i), .debug_req_i(debug_req), .halt_entry_address_in(hadr),
      .halt_exception_address_in(xadr), .dec_valid_i(dv), .dec_pc_i(dpc), .dec_ebreak_i(deb),
      .dec_mret_i(dmr), .dec_dret_i(ddr), .dec_exc_i(dex), .dec_exc_code_i(5'h02), .irq_i(irq),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_havereset_o(hr),
      .debug_running_o(run), .debug_halted_o(hlt), .redirect_o(rdr), .redirect_pc_o(rpc),
      .kill_decode_o(kill), .irq_ack_o(ack), .irq_id_o(iid));
   always #4 sys_clk_i = ~sys_clk_i;
   // Counts acks and ends a hang; a run takes under 2000 cycles.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (ack === 1'b1) acks++;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      rdv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rdv, d);
      chk({31'h0, er}, {31'h0, e});
   endtask : rd
   // One instruction in decode for one cycle; k is {exc, dret, mret, ebreak}.
   task automatic ins(input logic [3:0] k, input logic [31:0] p);
      @(posedge sys_clk_i);
      dv <= 1'b1;
      {dex, ddr, dmr, deb} <= k;
      dpc <= p;
      @(posedge sys_clk_i);
      dv <= 1'b0;
      {dex, ddr, dmr, deb} <= 4'h0;
      #1;
   endtask : ins
   function automatic logic [31:0] dcsr_of(input logic ebm, input logic [2:0] cause);
      dcsr_of = dbg_ctrl_pkg::DCSR_CONST;
      dcsr_of[dbg_ctrl_pkg::DCSR_EBREAKM_POS] = ebm;
      dcsr_of[dbg_ctrl_pkg::DCSR_CAUSE_LSB +: 3] = cause;
   endfunction : dcsr_of
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(38));
      pc = ($urandom() | 32'h0000_0100) & 32'hFFFF_FFFC;
      repeat (8) @(posedge sys_clk_i);
      chk(st, 32'h4);
      rstn_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk(st, 32'h4);
      req_go <= 1'b1;
      @(posedge sys_clk_i);
      req_go <= 1'b0;
      fetch_enable_i <= 1'b1;
      @(posedge sys_clk_i);
      #1;
      chk(st, 32'h1);
      rd(dbg_ctrl_pkg::OFS_DCSR, dcsr_of(1'b0, dbg_ctrl_pkg::CAUSE_HALTREQ), 1'b0);
      r = $urandom();
      wr(dbg_ctrl_pkg::OFS_DSCR1, r);
      rd(dbg_ctrl_pkg::OFS_DSCR1, r, 1'b0);
      rd(8'h38, 32'h0, 1'b1);
      wr(dbg_ctrl_pkg::OFS_TDATA2, pc);
      wr(dbg_ctrl_pkg::OFS_TDATA1, 32'h0000_0004);
      apb(1'b0, dbg_ctrl_pkg::OFS_TDATA1, 32'h0);
      chk({31'h0, rdv[dbg_ctrl_pkg::TD1_DMODE_POS]}, 32'h1);
      wr(dbg_ctrl_pkg::OFS_DCSR, 32'h0000_8000);
      wr(dbg_ctrl_pkg::OFS_MIE, 32'h0000_0800);
      wr(dbg_ctrl_pkg::OFS_MSTATUS, 32'h0000_0008);
      irq <= 32'h0000_0800;
      ins(4'h1, pc ^ 32'h10);
      chk(rpc, hadr);
      ins(4'h8, pc);
      chk(rpc, xadr);
      ins(4'h2, pc);
      chk(rpc, xadr);
      rd(dbg_ctrl_pkg::OFS_DCSR, dcsr_of(1'b1, dbg_ctrl_pkg::CAUSE_HALTREQ), 1'b0);
      irq <= 32'h0;
      chk(32'(acks), 32'h0);
      ins(4'h4, 32'h0);
      chk(st, 32'h2);
      wr(dbg_ctrl_pkg::OFS_TDATA2, ~pc);
      rd(dbg_ctrl_pkg::OFS_TDATA2, pc, 1'b0);
      rd(dbg_ctrl_pkg::OFS_DCSR, 32'h0, 1'b1);
      ins(4'h1, pc ^ 32'h20);
      chk(st, 32'h1);
      rd(dbg_ctrl_pkg::OFS_DPC, pc ^ 32'h20, 1'b0);
      rd(dbg_ctrl_pkg::OFS_DCSR, dcsr_of(1'b1, dbg_ctrl_pkg::CAUSE_EBREAK), 1'b0);
      ins(4'h4, 32'h0);
      ins(4'h0, pc);
      chk(st, 32'h1);
      rd(dbg_ctrl_pkg::OFS_DCSR, dcsr_of(1'b1, dbg_ctrl_pkg::CAUSE_TRIGGER), 1'b0);
      wr(dbg_ctrl_pkg::OFS_DCSR, 32'h0);
      wr(dbg_ctrl_pkg::OFS_TDATA1, 32'h0);
      r = $urandom() & 32'hFFFF_FF00;
      wr(dbg_ctrl_pkg::OFS_MTVEC, r);
      ins(4'h4, 32'h0);
      ins(4'h1, pc ^ 32'h30);
      chk(rpc, r);
      rd(dbg_ctrl_pkg::OFS_MEPC, pc ^ 32'h30, 1'b0);
      rd(dbg_ctrl_pkg::OFS_MCAUSE, dbg_ctrl_pkg::EXC_BREAK, 1'b0);
      apb(1'b0, dbg_ctrl_pkg::OFS_MSTATUS, 32'h0);
      chk({30'h0, rdv[dbg_ctrl_pkg::MST_MPIE_POS], rdv[dbg_ctrl_pkg::MST_MIE_POS]}, 32'h2);
      irq <= 32'h0000_0800;
      repeat (4) @(posedge sys_clk_i);
      chk(32'(acks), 32'h0);
      wr(dbg_ctrl_pkg::OFS_MSTATUS, 32'h0000_0008);
      repeat (4) @(posedge sys_clk_i);
      chk(32'(acks), 32'h1);
      chk({27'h0, iid}, 32'h0000_000B);
      irq <= 32'h0;
      req_len <= 8'h01;
      req_go <= 1'b1;
      dv <= 1'b1;
      dpc <= pc ^ 32'h40;
      @(posedge sys_clk_i);
      req_go <= 1'b0;
      while (hlt !== 1'b1) @(posedge sys_clk_i);
      dv <= 1'b0;
      rd(dbg_ctrl_pkg::OFS_DPC, pc ^ 32'h40, 1'b0);
      rd(dbg_ctrl_pkg::OFS_DCSR, dcsr_of(1'b0, dbg_ctrl_pkg::CAUSE_HALTREQ), 1'b0);
      end_sim();
   end
endmodule : tb
